// ==== sbta_pkg.sv ====
package sbta_pkg;
	// register byte addresses on the bus
	localparam logic [3:0] SBTA_CTRL_OFS = 4'h0;
	localparam logic [3:0] SBTA_DATA_OFS = 4'h4;
	localparam logic [3:0] SBTA_STAT_OFS = 4'h8;
	localparam logic [3:0] SBTA_MASK_OFS = 4'hC;
	// control register field positions
	localparam int SBTA_MODE_LO_POS = 0;
	localparam int SBTA_MODE_HI_POS = 1;
	localparam int SBTA_CLKSEL_POS = 2;
	localparam int SBTA_LOST_POS = 3;
	localparam int SBTA_DONE_POS = 4;
	localparam int SBTA_RUN_POS = 5;
	localparam int SBTA_OVF_POS = 6;
	localparam int SBTA_TOP_POS = 7;
	// status register event bit positions
	localparam int SBTA_EV_DONE_POS = 0;
	localparam int SBTA_EV_LOST_POS = 1;
	localparam int SBTA_EV_OVF_POS = 2;
	localparam int SBTA_EV_W = 3;
	// reset values
	localparam logic [1:0] SBTA_MODE_RST = 2'h0;
	localparam logic SBTA_CLKSEL_RST = 1'b0;
	localparam logic [2:0] SBTA_MASK_RST = 3'h0;
	// arbitration sample points
	localparam logic [8:0] SBTA_SAMPLE_BUS = 9'h038;
	localparam logic [8:0] SBTA_SAMPLE_PRE = 9'h008;
	localparam int SBTA_CNT_W = 9;

	typedef enum logic [1:0]
	{
		SBTA_MODE_IDLE = 2'b00,
		SBTA_MODE_MEAS = 2'b01,
		SBTA_MODE_ARB = 2'b10,
		SBTA_MODE_RSVD = 2'b11
	} sbta_mode_t;

	typedef struct packed
	{
		logic [3:0] adr;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
	} sbta_req_t;
endpackage

// ==== sbta_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// divides a tick source by two; output registered
module sbta_tick_div
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// source tick and divided tick
	input wire logic src_i,
	output logic tick_o
);
	logic phase;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phase <= 1'b0;
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= src_i & phase;
			if (src_i)
				phase <= ~phase;
		end
	end
endmodule // sbta_tick_div

// ==== sbta_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - low count byte readable; control write clears
// - mode 00 clears and holds counter
// - clksel 0: half bus, fall to fall
// - running flag while counting; done on stop
// - clksel 1: half prescaler, stop on rise
// - clksel 1: start on low receive level
// - already low at enable: start at once
// - mode 10: restart on transmit rise
// - sample rx at 38/08; low sets lost
// - lost flag forces transmit pin high
// - tx low before rx low: reset, disarm
// - mode codes: idle, measure, arbitrate, reserved
// - lost cleared only by mode-high zero write
// - overflow flag; control write clears done and overflow flags
// - counter top bit readable in control
module sbta_arbiter
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial side
	input wire logic rx_pin_i,
	input wire logic internal_tx_shift_out_i,
	input wire logic presc_tick_i,
	output logic tx_pin_o,
	// interrupt
	output logic irq_o
);
	import sbta_pkg::*;

	sbta_req_t req;
	logic rx_meta, rx_s, rx_d;
	logic tx_d;
	logic [1:0] arbiter_mode_sel;
	logic clksel;
	logic [8:0] cnt;
	logic counter_running_flag, measure_done_flag, arb_lost_flag, counter_overflow_flag;
	logic armed, seen_rx_low;
	logic [SBTA_EV_W-1:0] evt_stat, evt_mask;
	logic bus_half, pre_half, tick;
	logic ctrl_wr, stat_wr, mask_wr, acc;
	logic rx_fall, rx_rise, tx_rise, tx_fall, sample_hit;
	logic ev_done, ev_lost, ev_ovf;
	logic [SBTA_EV_W-1:0] ev_vec;
	logic [7:0] ctrl_rd;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
	assign acc = cyc_i & stb_i & ~ack_o;
	assign ctrl_wr = acc & req.we & req.sel[0] & hit(req.adr, SBTA_CTRL_OFS);
	assign stat_wr = acc & req.we & req.sel[0] & hit(req.adr, SBTA_STAT_OFS);
	assign mask_wr = acc & req.we & req.sel[0] & hit(req.adr, SBTA_MASK_OFS);

	// receive pin crosses in through two flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_meta <= 1'b1;
			rx_s <= 1'b1;
			rx_d <= 1'b1;
			tx_d <= 1'b1;
		end
		else
		begin
			rx_meta <= rx_pin_i;
			rx_s <= rx_meta;
			rx_d <= rx_s;
			tx_d <= internal_tx_shift_out_i;
		end
	end

	assign rx_fall = rx_d & ~rx_s;
	assign rx_rise = ~rx_d & rx_s;
	assign tx_rise = ~tx_d & internal_tx_shift_out_i;
	assign tx_fall = tx_d & ~internal_tx_shift_out_i;

	// half rate ticks for either counter clock
	sbta_tick_div u_bus_div
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(1'b1),
		.tick_o(bus_half)
	);

	sbta_tick_div u_pre_div
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.src_i(presc_tick_i),
		.tick_o(pre_half)
	);

	assign tick = clksel ? pre_half : bus_half;
	assign sample_hit = tick & (cnt == (clksel ? SBTA_SAMPLE_PRE : SBTA_SAMPLE_BUS));

	// control bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			arbiter_mode_sel <= SBTA_MODE_RST;
			clksel <= SBTA_CLKSEL_RST;
		end
		else if (ctrl_wr)
		begin
			arbiter_mode_sel <= req.dat[SBTA_MODE_HI_POS:SBTA_MODE_LO_POS];
			clksel <= req.dat[SBTA_CLKSEL_POS];
		end
	end

	// counter and measurement state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			counter_running_flag <= 1'b0;
			measure_done_flag <= 1'b0;
			counter_overflow_flag <= 1'b0;
			armed <= 1'b0;
			seen_rx_low <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			// any control write restarts the measurement from a clean slate
			cnt <= '0;
			measure_done_flag <= 1'b0;
			counter_overflow_flag <= 1'b0;
			counter_running_flag <= 1'b0;
			armed <= 1'b0;
			seen_rx_low <= 1'b0;
		end
		else
		begin
			case (sbta_mode_t'(arbiter_mode_sel))
				SBTA_MODE_IDLE:
				begin
					cnt <= '0;
					counter_running_flag <= 1'b0;
					armed <= 1'b0;
				end
				SBTA_MODE_MEAS:
				begin
					if (counter_running_flag)
					begin
						if ((!clksel && rx_fall) || (clksel && rx_rise))
						begin
							counter_running_flag <= 1'b0;
							measure_done_flag <= 1'b1;
						end
						else if (tick)
						begin
							{counter_overflow_flag, cnt} <= {counter_overflow_flag | (&cnt), cnt + 9'h001};
						end
					end
					else if (!measure_done_flag)
					begin
						// clksel 1 uses the level, so a line already low starts at once
						if ((!clksel && rx_fall) || (clksel && !rx_s))
							counter_running_flag <= 1'b1;
					end
				end
				SBTA_MODE_ARB:
				begin
					if (tx_rise)
					begin
						cnt <= '0;
						armed <= 1'b1;
						counter_running_flag <= 1'b1;
						seen_rx_low <= 1'b0;
					end
					else if (tx_fall && !seen_rx_low)
					begin
						cnt <= '0;
						armed <= 1'b0;
						counter_running_flag <= 1'b0;
					end
					else if (armed && tick)
					begin
						{counter_overflow_flag, cnt} <= {counter_overflow_flag | (&cnt), cnt + 9'h001};
					end
					if (!rx_s)
						seen_rx_low <= 1'b1;
				end
				default:
				begin
					counter_running_flag <= 1'b0;
				end
			endcase
		end
	end

	// arbitration lost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			arb_lost_flag <= 1'b0;
		else if (arbiter_mode_sel == SBTA_MODE_ARB && armed && sample_hit && !rx_s)
			arb_lost_flag <= 1'b1;
		else if (ctrl_wr && !req.dat[SBTA_MODE_HI_POS])
			arb_lost_flag <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_pin_o <= 1'b1;
		else
			tx_pin_o <= arb_lost_flag ? 1'b1 : internal_tx_shift_out_i;
	end

	// sticky events; set wins over a write-one clear
	assign ev_done = measure_done_flag;
	assign ev_lost = arb_lost_flag;
	assign ev_ovf = counter_overflow_flag;
	assign ev_vec = {ev_ovf, ev_lost, ev_done};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			evt_stat <= '0;
		else
			evt_stat <= (evt_stat & ~(stat_wr ? req.dat[SBTA_EV_W-1:0] : '0)) | ev_vec;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			evt_mask <= SBTA_MASK_RST;
		else if (mask_wr)
			evt_mask <= req.dat[SBTA_EV_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(evt_stat & evt_mask);
	end

	assign ctrl_rd = {cnt[8], counter_overflow_flag, counter_running_flag, measure_done_flag,
		arb_lost_flag, clksel, arbiter_mode_sel};

	// bus answer, one cycle after request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= acc;
			if (acc && !req.we)
			begin
				case (req.adr)
					SBTA_CTRL_OFS: dat_o <= {24'h000000, ctrl_rd};
					SBTA_DATA_OFS: dat_o <= {24'h000000, cnt[7:0]};
					SBTA_STAT_OFS: dat_o <= {29'h00000000, evt_stat};
					SBTA_MASK_OFS: dat_o <= {29'h00000000, evt_mask};
					default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	property p_idle_clear;
		@(posedge clk_i) disable iff (rst_i)
		(arbiter_mode_sel == SBTA_MODE_IDLE) |=> (cnt == 9'h000);
	endproperty
	a_idle_clear: assert property (p_idle_clear) else $error("counter not held in idle");

	property p_ctrl_wr_clears;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_wr |=> (cnt == 9'h000) && !measure_done_flag && !counter_overflow_flag;
	endproperty
	a_ctrl_wr_clears: assert property (p_ctrl_wr_clears) else $error("control write did not clear");

	property p_lost_forces_tx;
		@(posedge clk_i) disable iff (rst_i)
		arb_lost_flag |=> tx_pin_o;
	endproperty
	a_lost_forces_tx: assert property (p_lost_forces_tx) else $error("tx not forced high");

	property p_lost_set;
		@(posedge clk_i) disable iff (rst_i)
		(arbiter_mode_sel == SBTA_MODE_ARB && armed && sample_hit && !rx_s) |=> arb_lost_flag;
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("lost flag missed");

	property p_lost_hold;
		@(posedge clk_i) disable iff (rst_i)
		(arb_lost_flag && !(ctrl_wr && !req.dat[SBTA_MODE_HI_POS])) |=> arb_lost_flag;
	endproperty
	a_lost_hold: assert property (p_lost_hold) else $error("lost flag dropped");

	property p_tx_restart;
		@(posedge clk_i) disable iff (rst_i)
		(arbiter_mode_sel == SBTA_MODE_ARB && tx_rise && !ctrl_wr) |=> (cnt == 9'h000) && armed;
	endproperty
	a_tx_restart: assert property (p_tx_restart) else $error("no restart on tx rise");

	property p_stop_done;
		@(posedge clk_i) disable iff (rst_i)
		(arbiter_mode_sel == SBTA_MODE_MEAS && counter_running_flag && !clksel && rx_fall && !ctrl_wr)
		|=> measure_done_flag && !counter_running_flag;
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("measure did not stop");

	property p_hold_stopped;
		@(posedge clk_i) disable iff (rst_i)
		(!counter_running_flag && arbiter_mode_sel == SBTA_MODE_MEAS && !ctrl_wr) |=> $stable(cnt);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) else $error("count moved while stopped");

	property p_low_start;
		@(posedge clk_i) disable iff (rst_i)
		(arbiter_mode_sel == SBTA_MODE_MEAS && clksel && !rx_s && !counter_running_flag
			&& !measure_done_flag && !ctrl_wr) |=> counter_running_flag;
	endproperty
	a_low_start: assert property (p_low_start) else $error("break count not started");

	c_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(measure_done_flag));
	c_lost: cover property (@(posedge clk_i) disable iff (rst_i) $rose(arb_lost_flag));
	c_ovf: cover property (@(posedge clk_i) disable iff (rst_i) $rose(counter_overflow_flag));
endmodule // sbta_arbiter
`default_nettype wire

// ==== sbta_node_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// other node on the shared line; wired-and, pull-up when released
module sbta_node_model
(
	// our transmit pin
	input wire logic tx_pin_i,
	// other node pulls the line dominant low
	input wire logic dominant_i,
	// line as seen by the receiver
	output logic rx_o
);
	assign rx_o = tx_pin_i & ~dominant_i;
endmodule // sbta_node_model
`default_nettype wire

// ==== test_serial_bit_time_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_bit_time_arbiter;
	import sbta_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, tx_int, presc, dom, rx, tx_pin, ack, irq;
	logic [3:0] adr, sel;
	logic [31:0] dat, rdat, r;
	logic [1:0] pdiv;
	int n_mismatch, n_checks, cycles;

	sbta_arbiter i_sbta_arbiter (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .rx_pin_i(rx),
		.internal_tx_shift_out_i(tx_int), .presc_tick_i(presc), .tx_pin_o(tx_pin), .irq_o(irq));
	sbta_node_model i_sbta_node_model (.tx_pin_i(tx_pin), .dominant_i(dom), .rx_o(rx));

	initial
	begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end

	// prescaler tick every fourth cycle
	always @(posedge clk_i)
	begin
		pdiv <= pdiv + 2'h1;
		presc <= (pdiv == 2'h3);
		cycles <= cycles + 1;
		if (cycles > 20000)
		begin
			n_mismatch = n_mismatch + 1;
			close_out();
		end
	end

	task automatic close_out();
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		n_checks = n_checks + 1;
		if (!(got >= lo && got <= hi) || $isunknown(got))
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic t_reset();
		chk({31'h0, tx_pin}, 32'h1);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r, 32'h0);
		wb(SBTA_DATA_OFS, 0, 0);
		chk(r, 32'h0);
		wb(4'h2, 0, 0);
		chk(r, 32'h0);
		wb(SBTA_DATA_OFS, 1, 32'hFF);
		wb(SBTA_DATA_OFS, 0, 0);
		chk(r, 32'h0);
	endtask

	task automatic t_meas0();
		wb(SBTA_CTRL_OFS, 1, 32'h01);
		dom <= 1'b1;
		idle(10);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h30, 32'h20);
		idle(8);
		dom <= 1'b0;
		idle(20);
		dom <= 1'b1;
		idle(10);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h30, 32'h10);
		wb(SBTA_DATA_OFS, 0, 0);
		chk_rng(r, 32'h13, 32'h15);
		idle(30);
		dom <= 1'b0;
		wb(SBTA_DATA_OFS, 0, 0);
		chk_rng(r, 32'h13, 32'h15);
		wb(SBTA_CTRL_OFS, 1, 32'h00);
		wb(SBTA_DATA_OFS, 0, 0);
		chk(r, 32'h0);
	endtask

	task automatic t_meas1();
		dom <= 1'b1;
		idle(6);
		wb(SBTA_CTRL_OFS, 1, 32'h05);
		idle(80);
		dom <= 1'b0;
		idle(10);
		wb(SBTA_DATA_OFS, 0, 0);
		chk_rng(r, 32'h9, 32'hC);
		// line high at enable: waits for a low level
		wb(SBTA_CTRL_OFS, 1, 32'h05);
		idle(10);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h30, 32'h00);
		dom <= 1'b1;
		idle(40);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h30, 32'h20);
		dom <= 1'b0;
		idle(10);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h30, 32'h10);
		wb(SBTA_DATA_OFS, 0, 0);
		chk_rng(r, 32'h5, 32'h6);
		wb(SBTA_CTRL_OFS, 1, 32'h00);
	endtask

	task automatic t_ovf();
		wb(SBTA_CTRL_OFS, 1, 32'h01);
		dom <= 1'b1;
		idle(4);
		dom <= 1'b0;
		idle(600);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h80, 32'h80);
		idle(500);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h40, 32'h40);
		wb(SBTA_CTRL_OFS, 1, 32'h00);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'hF0, 32'h00);
		wb(SBTA_STAT_OFS, 1, 32'h7);
	endtask

	// one transmit rise; other node dominant or not
	task automatic arb_bit(input logic d, input logic [31:0] exp);
		tx_int <= 1'b0;
		idle(4);
		tx_int <= 1'b1;
		dom <= d;
		idle(140);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h08, exp);
	endtask

	task automatic t_arb();
		wb(SBTA_MASK_OFS, 1, 32'h2);
		wb(SBTA_CTRL_OFS, 1, 32'h02);
		arb_bit(1'b0, 32'h0);
		arb_bit(1'b1, 32'h8);
		tx_int <= 1'b0;
		idle(3);
		chk({31'h0, tx_pin}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(SBTA_CTRL_OFS, 1, 32'h02);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h08, 32'h8);
		// pin forced high, so no echo: a tx fall with no low seen must disarm
		dom <= 1'b0;
		idle(4);
		tx_int <= 1'b1;
		idle(20);
		tx_int <= 1'b0;
		idle(20);
		wb(SBTA_DATA_OFS, 0, 0);
		chk(r, 32'h0);
		wb(SBTA_CTRL_OFS, 1, 32'h00);
		wb(SBTA_CTRL_OFS, 0, 0);
		chk(r & 32'h08, 32'h0);
		dom <= 1'b0;
		wb(SBTA_STAT_OFS, 1, 32'h2);
		idle(3);
		chk({31'h0, irq}, 32'h0);
		idle(2);
		chk({31'h0, tx_pin}, 32'h0);
		tx_int <= 1'b1;
	endtask

	initial
	begin
		n_mismatch = 0;
		n_checks = 0;
		cycles = 0;
		pdiv = 2'h0;
		presc = 1'b0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		sel = 4'hF;
		dat = 32'h0;
		tx_int = 1'b1;
		dom = 1'b0;
		idle(16);
		rst_i <= 1'b0;
		t_reset();
		t_meas0();
		t_meas1();
		t_ovf();
		t_arb();
		close_out();
	end
endmodule // test_serial_bit_time_arbiter
`default_nettype wire
